// ---- src/psrc_ch_if.sv ----
// Purpose: Link between the command decoder and one channel
// Assumes: Strobes are one-cycle pulses
// Notes: Decoder drives the write side, channel drives its state
interface psrc_ch_if;
  logic wr_run;
  logic wr_cfg;
  logic [7:0] wdata;
  logic [7:0] run_byte;
  logic [7:0] cfg_byte;
  logic run_on;
  logic seq_off;
  logic fast_off;
  logic [1:0] margin;
  logic ign_faults;
  modport ctl (output wr_run, wr_cfg, wdata,
    input run_byte, cfg_byte, run_on, seq_off, fast_off, margin, ign_faults);
  modport chan (input wr_run, wr_cfg, wdata,
    output run_byte, cfg_byte, run_on, seq_off, fast_off, margin, ign_faults);
endinterface : psrc_ch_if

// ---- src/psrc_chan.sv ----
// Purpose: Run, margin and fault-handling state of one channel
// Assumes: Write strobes arrive already validated
// Notes: Run state follows the stored bytes one cycle later
module psrc_chan
  import psrc_pkg::*;
(
  // Clock and control
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Channel control pin, active high
  input wire logic pin_in,
  // Decoder side
  psrc_ch_if.chan ch
);
  logic [1:0] ctrl;
  logic use_bus;
  logic use_pin;
  logic on_nxt;

  assign ctrl = ch.run_byte[CTRL_HI:CTRL_LO];
  assign use_bus = ch.cfg_byte[CFG_USE_BUS];
  assign use_pin = ch.cfg_byte[CFG_USE_PIN];

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ch.run_byte <= RUN_RST;
      ch.cfg_byte <= ONOFF_RST;
    end else if (ce_in) begin
      if (ch.wr_run) ch.run_byte <= ch.wdata & RUN_WR_MASK;
      if (ch.wr_cfg) ch.cfg_byte <= (ch.wdata & ONOFF_WR_MASK) | ONOFF_FIXED;
    end
  end

  // Bus control bits count only when the bus is enabled as a source
  always_comb begin
    unique case ({use_bus, use_pin})
      2'b11: on_nxt = (ctrl == CTRL_ON) && pin_in;
      2'b10: on_nxt = (ctrl == CTRL_ON);
      2'b01: on_nxt = pin_in;
      2'b00: on_nxt = !ch.cfg_byte[CFG_ON];
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ch.run_on <= 1'b0;
      ch.seq_off <= 1'b0;
      ch.fast_off <= 1'b0;
      ch.margin <= MRG_NOM;
      ch.ign_faults <= 1'b0;
    end else if (ce_in) begin
      ch.run_on <= on_nxt;
      ch.seq_off <= !on_nxt && use_bus && ctrl == CTRL_SEQ;
      ch.fast_off <= !on_nxt && ((use_bus && ctrl == CTRL_OFF) ||
        (use_pin && !pin_in && ch.cfg_byte[CFG_FAST]));
      // Margin applies whatever the on/off source, also while sequencing off
      ch.margin <= ch.run_byte[MRG_HI:MRG_LO];
      ch.ign_faults <= ch.run_byte[MRG_HI:MRG_LO] != MRG_NOM &&
        ch.run_byte[FLT_HI:FLT_LO] == FLT_IGN;
    end
  end

  property p_bus_on;
    @(posedge clk_in) disable iff (rst_in)
      (ce_in && use_bus && !use_pin && ctrl == CTRL_ON) |=> ch.run_on;
  endproperty
  a_bus_on: assert property (p_bus_on) else $error("Bus on not obeyed");

  property p_bus_ignored;
    @(posedge clk_in) disable iff (rst_in)
      (ce_in && !use_bus && use_pin) |=> (ch.run_on == $past(pin_in));
  endproperty
  a_bus_ignored: assert property (p_bus_ignored) else $error("Bus bits not ignored");

  property p_margin;
    @(posedge clk_in) disable iff (rst_in)
      ce_in |=> (ch.margin == $past(ch.run_byte[5:4]));
  endproperty
  a_margin: assert property (p_margin) else $error("Margin not applied");
endmodule : psrc_chan

// ---- src/psrc_fmt_dec.sv ----
// Purpose: Splits a data word into signed mantissa and exponent
// Assumes: Word and selector are held by the caller
// Notes: Register and custom words pass as raw values
module psrc_fmt_dec
  import psrc_pkg::*;
(
  // Clock and control
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Word in
  input wire psrc_fmt_e sel_in,
  input wire logic [15:0] word_in,
  // Result
  output logic signed [16:0] mant_out,
  output logic signed [4:0] exp_out
);
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mant_out <= 17'sh00000;
      exp_out <= 5'sh00;
    end else if (ce_in) begin
      unique case (sel_in)
        FMT_L11: begin
          mant_out <= {{6{word_in[MAN_HI]}}, word_in[MAN_HI:0]};
          exp_out <= word_in[EXP_HI:EXP_LO];
        end
        FMT_L16: begin
          mant_out <= {1'b0, word_in};
          exp_out <= L16_EXP;
        end
        FMT_REG: begin
          mant_out <= {1'b0, word_in};
          exp_out <= 5'sh00;
        end
        FMT_CF: begin
          mant_out <= {1'b0, word_in};
          exp_out <= CF_EXP;
        end
      endcase
    end
  end

  property p_l16_exp;
    @(posedge clk_in) disable iff (rst_in)
      (ce_in && sel_in == FMT_L16) |=> (exp_out == -5'sd13 && mant_out[16] == 1'b0);
  endproperty
  a_l16_exp: assert property (p_l16_exp) else $error("L16 exponent wrong");

  property p_l11_split;
    @(posedge clk_in) disable iff (rst_in)
      (ce_in && sel_in == FMT_L11) |=>
        (exp_out == $past(word_in[15:11]) && mant_out[10:0] == $past(word_in[10:0])
         && mant_out[16] == $past(word_in[10]));
  endproperty
  a_l11_split: assert property (p_l11_split) else $error("L11 split wrong");
endmodule : psrc_fmt_dec

// ---- src/psrc_pkg.sv ----
// Purpose: Shared constants for the page select and run control block
// Assumes: One 50 MHz clock, synchronous active-high reset
// Notes: Command codes and the run-control reset values are plain defaults
package psrc_pkg;
  localparam int NUM_CH = 8;
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_RUN = 8'h01;
  localparam logic [7:0] CMD_ONOFF = 8'h02;
  localparam logic [7:0] CMD_CLEAR = 8'h03;
  localparam logic [7:0] CMD_MASK = 8'hE4;
  localparam logic [7:0] PAGE_ALL = 8'hFF;
  localparam logic [7:0] PAGE_LAST = 8'h07;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hFF;
  localparam logic [7:0] RUN_RST = 8'h00;
  localparam logic [7:0] ONOFF_RST = 8'h1E;
  localparam logic [7:0] ONOFF_WR_MASK = 8'h1D;
  localparam logic [7:0] ONOFF_FIXED = 8'h02;
  localparam logic [7:0] RUN_WR_MASK = 8'hFC;
  localparam logic [7:0] RD_UNDEF = 8'h00;
  localparam int CTRL_HI = 7;
  localparam int CTRL_LO = 6;
  localparam int MRG_HI = 5;
  localparam int MRG_LO = 4;
  localparam int FLT_HI = 3;
  localparam int FLT_LO = 2;
  localparam int CFG_ON = 4;
  localparam int CFG_USE_BUS = 3;
  localparam int CFG_USE_PIN = 2;
  localparam int CFG_FAST = 0;
  localparam logic [1:0] CTRL_OFF = 2'h0;
  localparam logic [1:0] CTRL_SEQ = 2'h1;
  localparam logic [1:0] CTRL_ON = 2'h2;
  localparam logic [1:0] MRG_NOM = 2'h0;
  localparam logic [1:0] MRG_LOW = 2'h1;
  localparam logic [1:0] MRG_HIGH = 2'h2;
  localparam logic [1:0] FLT_IGN = 2'h1;
  localparam logic [1:0] FLT_ACT = 2'h2;
  localparam int EXP_HI = 15;
  localparam int EXP_LO = 11;
  localparam int MAN_HI = 10;
  localparam logic signed [4:0] L16_EXP = -5'sd13;
  localparam logic signed [4:0] CF_EXP = 5'sd0;
  typedef enum logic [1:0] {FMT_L11, FMT_L16, FMT_REG, FMT_CF} psrc_fmt_e;
endpackage : psrc_pkg

// ---- src/psrc_top.sv ----
// Purpose: Page select, global page mask and run control command decoder
// Assumes: Commands arrive one per cycle at most, synchronous to clk_in
// Notes: Paged reads answer one cycle after the request; paged writes land in the channel two cycles after it
module psrc_top
  import psrc_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Command port
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [7:0] cmd_data_in,
  output logic rsp_valid_out,
  output logic [7:0] rsp_data_out,
  // Status
  output logic [7:0] page_out,
  output logic cml_fault_out,
  // Channel pins and state
  input wire logic [NUM_CH-1:0] channel_control_pin_in,
  output logic [NUM_CH-1:0] run_out,
  output logic [NUM_CH-1:0] seq_off_out,
  output logic [NUM_CH-1:0] fast_off_out,
  output logic [NUM_CH-1:0] margin_low_out,
  output logic [NUM_CH-1:0] margin_high_out,
  output logic [NUM_CH-1:0] ignore_faults_out,
  // Data format decoder
  input wire logic [1:0] fmt_sel_in,
  input wire logic [15:0] fmt_word_in,
  output logic signed [16:0] fmt_mant_out,
  output logic signed [4:0] fmt_exp_out
);
  // Valid run byte; with bus control off the control field is only checked for 11
  function automatic logic op_ok(input logic [7:0] b, input logic use_bus);
    logic [1:0] c;
    logic [1:0] m;
    logic [1:0] f;
    c = b[CTRL_HI:CTRL_LO];
    m = b[MRG_HI:MRG_LO];
    f = b[FLT_HI:FLT_LO];
    if (c == 2'h3) return 1'b0;
    if (use_bus && c == CTRL_OFF) return 1'b1;
    if (m == MRG_NOM) return 1'b1;
    if (m == 2'h3) return 1'b0;
    return f == FLT_IGN || f == FLT_ACT;
  endfunction : op_ok

  psrc_ch_if ch[NUM_CH]();

  logic [7:0] page_r;
  logic [7:0] mask_r;
  logic cml_fault_r;
  logic [NUM_CH-1:0] wr_run_r;
  logic [NUM_CH-1:0] wr_cfg_r;
  logic [7:0] wdata_r;
  logic rsp_valid_r;
  logic [7:0] rsp_data_r;
  logic [NUM_CH-1:0] tgt;
  logic [NUM_CH-1:0] ch_ok;
  logic [NUM_CH-1:0] cfg_use_bus;
  logic [7:0] sel_run;
  logic [7:0] sel_cfg;
  logic [7:0] run_bytes [NUM_CH];
  logic [7:0] cfg_bytes [NUM_CH];
  logic page_one;
  logic page_all;
  logic page_bad;
  logic do_wr;
  logic do_rd;
  logic run_ok;
  logic set_cml;
  logic clr_cml;

  assign page_one = page_r <= PAGE_LAST;
  assign page_all = page_r == PAGE_ALL;
  assign page_bad = !page_one && !page_all;
  assign do_wr = ce_in && cmd_valid_in && cmd_write_in;
  assign do_rd = ce_in && cmd_valid_in && !cmd_write_in;
  assign run_ok = &ch_ok;

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    // Broadcast reaches only the channels enabled in the mask
    assign tgt[i] = page_all ? mask_r[i] : (page_r == 8'(i));
    assign cfg_use_bus[i] = ch[i].cfg_byte[CFG_USE_BUS];
    // Interface arrays take constant indices only, so the readback mux reads these copies
    assign run_bytes[i] = ch[i].run_byte;
    assign cfg_bytes[i] = ch[i].cfg_byte;
    assign ch_ok[i] = !tgt[i] || op_ok(cmd_data_in, cfg_use_bus[i]);
    assign ch[i].wr_run = wr_run_r[i];
    assign ch[i].wr_cfg = wr_cfg_r[i];
    assign ch[i].wdata = wdata_r;
    assign run_out[i] = ch[i].run_on;
    assign seq_off_out[i] = ch[i].seq_off;
    assign fast_off_out[i] = ch[i].fast_off;
    assign margin_low_out[i] = ch[i].margin == MRG_LOW;
    assign margin_high_out[i] = ch[i].margin == MRG_HIGH;
    assign ignore_faults_out[i] = ch[i].ign_faults;

    psrc_chan u_chan (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .pin_in(channel_control_pin_in[i]),
      .ch(ch[i])
    );
  end

  // Paged readback of the selected channel
  always_comb begin
    sel_run = RD_UNDEF;
    sel_cfg = RD_UNDEF;
    for (int k = 0; k < NUM_CH; k++) begin
      if (page_r == 8'(k)) begin
        sel_run = run_bytes[k];
        sel_cfg = cfg_bytes[k];
      end
    end
  end

  // Fault sources: reserved pages, broadcast misuse, reserved run bytes, unknown codes
  always_comb begin
    set_cml = 1'b0;
    clr_cml = 1'b0;
    if (do_wr) begin
      unique case (cmd_code_in)
        CMD_PAGE: set_cml = 1'b0;
        CMD_MASK: set_cml = 1'b0;
        CMD_CLEAR: clr_cml = 1'b1;
        CMD_RUN: set_cml = page_bad || !run_ok;
        CMD_ONOFF: set_cml = page_bad;
        default: set_cml = 1'b1;
      endcase
    end else if (do_rd) begin
      unique case (cmd_code_in)
        CMD_PAGE: set_cml = 1'b0;
        CMD_MASK: set_cml = 1'b0;
        CMD_RUN: set_cml = !page_one;
        CMD_ONOFF: set_cml = !page_one;
        default: set_cml = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      page_r <= PAGE_RST;
    end else if (do_wr && cmd_code_in == CMD_PAGE) begin
      page_r <= cmd_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mask_r <= MASK_RST;
    end else if (do_wr && cmd_code_in == CMD_MASK) begin
      mask_r <= cmd_data_in;
    end
  end

  // A new fault in the clearing cycle survives the clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cml_fault_r <= 1'b0;
    end else if (ce_in) begin
      if (set_cml) cml_fault_r <= 1'b1;
      else if (clr_cml) cml_fault_r <= 1'b0;
    end
  end

  // Only run and enable-source writes fan out; a rejected run byte touches no channel
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_run_r <= '0;
      wr_cfg_r <= '0;
      wdata_r <= 8'h00;
    end else if (ce_in) begin
      wr_run_r <= '0;
      wr_cfg_r <= '0;
      if (do_wr && !page_bad && cmd_code_in == CMD_RUN && run_ok) begin
        wr_run_r <= tgt;
      end
      if (do_wr && !page_bad && cmd_code_in == CMD_ONOFF) begin
        wr_cfg_r <= tgt;
      end
      if (do_wr) wdata_r <= cmd_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 8'h00;
    end else if (ce_in) begin
      rsp_valid_r <= do_rd;
      if (do_rd) begin
        unique case (cmd_code_in)
          CMD_PAGE: rsp_data_r <= page_r;
          CMD_MASK: rsp_data_r <= mask_r;
          CMD_RUN: rsp_data_r <= page_one ? sel_run : RD_UNDEF;
          CMD_ONOFF: rsp_data_r <= page_one ? sel_cfg : RD_UNDEF;
          default: rsp_data_r <= RD_UNDEF;
        endcase
      end
    end
  end

  assign rsp_valid_out = rsp_valid_r;
  assign rsp_data_out = rsp_data_r;
  assign page_out = page_r;
  assign cml_fault_out = cml_fault_r;

  psrc_fmt_dec u_fmt (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .sel_in(psrc_fmt_e'(fmt_sel_in)),
    .word_in(fmt_word_in),
    .mant_out(fmt_mant_out),
    .exp_out(fmt_exp_out)
  );

  sequence s_run_wr;
    do_wr && cmd_code_in == CMD_RUN;
  endsequence

  sequence s_broadcast_run;
    s_run_wr ##0 page_all && run_ok;
  endsequence

  property p_page_sel;
    @(posedge clk_in) disable iff (rst_in)
      (do_wr && cmd_code_in == CMD_PAGE) |=> (page_r == $past(cmd_data_in));
  endproperty
  a_page_sel: assert property (p_page_sel) else $error("Page not stored");

  property p_single_page;
    @(posedge clk_in) disable iff (rst_in)
      (s_run_wr ##0 page_one && run_ok) |=> (wr_run_r == (8'h01 << $past(page_r[2:0])));
  endproperty
  a_single_page: assert property (p_single_page) else $error("Wrong channel");

  property p_global_mask;
    @(posedge clk_in) disable iff (rst_in)
      s_broadcast_run |=> (wr_run_r == $past(mask_r));
  endproperty
  a_global_mask: assert property (p_global_mask) else $error("Mask not honoured");

  property p_no_global_other;
    @(posedge clk_in) disable iff (rst_in)
      (do_wr && cmd_code_in != CMD_RUN && cmd_code_in != CMD_ONOFF)
        |=> (wr_run_r == '0 && wr_cfg_r == '0);
  endproperty
  a_no_global_other: assert property (p_no_global_other) else $error("Stray fan-out");

  property p_ff_read_cml;
    @(posedge clk_in) disable iff (rst_in)
      (do_rd && page_all && cmd_code_in == CMD_RUN) |=> (cml_fault_r && rsp_valid_r);
  endproperty
  a_ff_read_cml: assert property (p_ff_read_cml) else $error("No fault on FF read");

  property p_reserved_reject;
    @(posedge clk_in) disable iff (rst_in)
      (s_run_wr ##0 !run_ok) |=> (wr_run_r == '0 && cml_fault_r);
  endproperty
  a_reserved_reject: assert property (p_reserved_reject) else $error("Bad byte taken");

  property p_run_lands;
    @(posedge clk_in) disable iff (rst_in)
      (s_run_wr ##0 page_one && run_ok) ##1
        (ce_in && !(do_wr && cmd_code_in == CMD_PAGE)) |=>
        (sel_run == ($past(cmd_data_in, 2) & RUN_WR_MASK));
  endproperty
  a_run_lands: assert property (p_run_lands) else $error("Run byte lost");

  property p_mask_reset;
    @(posedge clk_in) $past(rst_in) |-> (mask_r == 8'hFF);
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("Mask reset wrong");
endmodule : psrc_top

// ---- tb/psrc_host_model.sv ----
// Purpose: Host controller model issuing commands on the command port
// Assumes: One command per take edge, read answer a few cycles later
// Notes: Released code and data lines show inverted values so stale data is never mistaken
module psrc_host_model
  import psrc_pkg::*;
#(
  parameter int OFF_MIN_CYC = 16
)
(
  // Clock
  input wire logic clk_in,
  // Answer
  input wire logic rsp_valid_in,
  input wire logic [7:0] rsp_data_in,
  // Request
  output logic cmd_valid_out,
  output logic cmd_write_out,
  output logic [7:0] cmd_code_out,
  output logic [7:0] cmd_data_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cmd_valid_out = 1'b0;
    cmd_write_out = 1'b0;
    cmd_code_out = 8'h00;
    cmd_data_out = 8'h00;
  end

  task automatic send(input logic wr, input logic [7:0] code, input logic [7:0] data);
    @(posedge clk_in);
    cmd_valid_out <= 1'b1;
    cmd_write_out <= wr;
    cmd_code_out <= code;
    cmd_data_out <= data;
    @(posedge clk_in);
    cmd_valid_out <= 1'b0;
    cmd_code_out <= ~code;
    cmd_data_out <= ~data;
  endtask : send

  // Page writes from the bench use only 0x00..0x07 or 0xFF
  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    send(1'b1, code, data);
  endtask : wr

  task automatic rd(input logic [7:0] code, output logic [7:0] data, output logic ok);
    send(1'b0, code, 8'h00);
    ok = 1'b0;
    data = 8'h00;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk_in);
      if (rsp_valid_in === 1'b1) begin
        ok = 1'b1;
        data = rsp_data_in;
      end
    end
  endtask : rd

  // Minimum off time before a channel is turned back on by command
  task automatic wait_off();
    repeat (OFF_MIN_CYC) @(posedge clk_in);
  endtask : wait_off
endmodule : psrc_host_model

// ---- tb/psrc_top_tb_top.sv ----
// Purpose: Self-checking bench for page select and run control
// Assumes: Output changes land within four edges of a command take
// Notes: ce_in is held high; frozen cycles are not exercised
module psrc_top_tb_top;
  import psrc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_in;
  logic rst_in;
  logic ce_in;
  logic cmd_valid, cmd_write, rsp_valid, cml;
  logic [7:0] cmd_code, cmd_data, rsp_data, page;
  logic [7:0] pin, run, seqo, fasto, mlo, mhi, ign;
  logic [1:0] fmt_sel;
  logic [15:0] fmt_word;
  logic signed [16:0] fmt_mant;
  logic signed [4:0] fmt_exp;
  int checks = 0;
  int n_fail = 0;
  logic [7:0] d;
  logic ok;

  // Run byte, readback, {run, seq_off, fast_off, low, high, ignore} of one channel
  localparam logic [7:0] OPV[9] = '{8'h83, 8'h94, 8'h98, 8'hA4, 8'hA8, 8'h40, 8'h54, 8'h68, 8'h00};
  localparam logic [7:0] OPR[9] = '{8'h80, 8'h94, 8'h98, 8'hA4, 8'hA8, 8'h40, 8'h54, 8'h68, 8'h00};
  localparam logic [5:0] OPX[9] = '{6'h20, 6'h25, 6'h24, 6'h23, 6'h22, 6'h10, 6'h15, 6'h12, 6'h08};
  localparam logic [7:0] RSV[3] = '{8'hC0, 8'hB0, 8'h90};
  localparam logic [1:0] FSEL[5] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h3};
  localparam logic [15:0] FWD[5] = '{16'hD280, 16'h0FFF, 16'h9800, 16'hFFFF, 16'h1234};
  localparam logic [21:0] FEXP[5] = '{{17'h00280, 5'h1A}, {17'h1FFFF, 5'h01},
    {17'h09800, 5'h13}, {17'h0FFFF, 5'h13}, {17'h01234, 5'h00}};

  psrc_top i_psrc_top (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write), .cmd_code_in(cmd_code),
    .cmd_data_in(cmd_data), .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data),
    .page_out(page), .cml_fault_out(cml), .channel_control_pin_in(pin), .run_out(run),
    .seq_off_out(seqo), .fast_off_out(fasto), .margin_low_out(mlo), .margin_high_out(mhi),
    .ignore_faults_out(ign), .fmt_sel_in(fmt_sel), .fmt_word_in(fmt_word),
    .fmt_mant_out(fmt_mant), .fmt_exp_out(fmt_exp));

  psrc_host_model i_psrc_host_model (.clk_in(clk_in), .rsp_valid_in(rsp_valid),
    .rsp_data_in(rsp_data), .cmd_valid_out(cmd_valid), .cmd_write_out(cmd_write),
    .cmd_code_out(cmd_code), .cmd_data_out(cmd_data));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rdchk(input string nm, input logic [7:0] code, input logic [7:0] e);
    i_psrc_host_model.rd(code, d, ok);
    chk({nm, " answered"}, 32'h1, {31'h0, ok});
    chk(nm, {24'h0, e}, {24'h0, d});
  endtask : rdchk

  task automatic settle();
    repeat (4) @(posedge clk_in);
    #1;
  endtask : settle

  task automatic conclude();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  initial begin
    #(20ns * 6000);
    n_fail++;
    conclude();
  end

  initial begin
    rst_in = 1'b1;
    ce_in = 1'b1;
    pin = 8'hFF;
    fmt_sel = 2'h0;
    fmt_word = 16'h0000;
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    #1;
    chk("page reset", {24'h0, PAGE_RST}, {24'h0, page});
    chk("run reset", 32'h0, {24'h0, run});
    rdchk("mask reset", CMD_MASK, MASK_RST);
    rdchk("onoff reset", CMD_ONOFF, ONOFF_RST);
    $display("test reset done");

    for (int p = 0; p < NUM_CH; p++) begin
      i_psrc_host_model.wr(CMD_PAGE, 8'(p));
      i_psrc_host_model.wr(CMD_RUN, 8'h80);
      settle();
      chk("run per page", 32'((1 << (p + 1)) - 1), {24'h0, run});
      rdchk("page readback", CMD_PAGE, 8'(p));
    end
    $display("test pages done");

    i_psrc_host_model.wr(CMD_PAGE, 8'h03);
    for (int i = 0; i < 9; i++) begin
      i_psrc_host_model.wr(CMD_RUN, OPV[i]);
      settle();
      chk("chan3 state", {26'h0, OPX[i]},
        {26'h0, run[3], seqo[3], fasto[3], mlo[3], mhi[3], ign[3]});
      rdchk("run readback", CMD_RUN, OPR[i]);
    end
    $display("test run codes done");

    i_psrc_host_model.wait_off();
    i_psrc_host_model.wr(CMD_RUN, 8'h80);
    for (int i = 0; i < 3; i++) begin
      i_psrc_host_model.wr(CMD_RUN, RSV[i]);
      settle();
      chk("reserved fault", 32'h1, {31'h0, cml});
      rdchk("reserved kept", CMD_RUN, 8'h80);
      i_psrc_host_model.wr(CMD_CLEAR, 8'h00);
      settle();
      chk("fault cleared", 32'h0, {31'h0, cml});
    end
    $display("test reserved done");

    i_psrc_host_model.wr(CMD_PAGE, PAGE_ALL);
    i_psrc_host_model.wr(CMD_MASK, 8'h5A);
    i_psrc_host_model.wr(CMD_RUN, 8'h00);
    settle();
    chk("masked broadcast", 32'hA5, {24'h0, run});
    rdchk("mask readback", CMD_MASK, 8'h5A);
    i_psrc_host_model.wr(CMD_MASK, 8'hFF);
    i_psrc_host_model.wait_off();
    i_psrc_host_model.wr(CMD_RUN, 8'h80);
    settle();
    chk("full broadcast", 32'hFF, {24'h0, run});
    rdchk("global read data", CMD_RUN, RD_UNDEF);
    chk("global read fault", 32'h1, {31'h0, cml});
    i_psrc_host_model.wr(CMD_CLEAR, 8'h00);
    i_psrc_host_model.wr(CMD_ONOFF, 8'h16);
    i_psrc_host_model.wr(CMD_RUN, 8'h14);
    settle();
    chk("bus ignored run", 32'hFF, {24'h0, run});
    chk("bus off margin", 32'hFFFF, {16'h0, mlo, ign});
    chk("global onoff ok", 32'h0, {31'h0, cml});
    @(posedge clk_in);
    pin[0] <= 1'b0;
    settle();
    chk("pin off", 32'hFE, {24'h0, run});
    i_psrc_host_model.wr(CMD_ONOFF, 8'h0A);
    settle();
    chk("bus only off", 32'h00FF, {16'h0, run, fasto});
    i_psrc_host_model.wait_off();
    i_psrc_host_model.wr(CMD_RUN, 8'h80);
    settle();
    chk("bus only run", 32'hFF, {24'h0, run});
    $display("test global done");

    for (int i = 0; i < 5; i++) begin
      @(posedge clk_in);
      fmt_sel <= FSEL[i];
      fmt_word <= FWD[i];
      repeat (2) @(posedge clk_in);
      #1;
      chk("format", {10'h0, FEXP[i]}, {10'h0, fmt_mant, fmt_exp});
    end
    @(posedge clk_in);
    fmt_sel <= 2'h2;
    fmt_word <= 16'h00A5;
    repeat (3) @(posedge clk_in);
    #1;
    chk("register word", 32'h00A5, {15'h0, fmt_mant});
    $display("test formats done");
    conclude();
  end
endmodule : psrc_top_tb_top
